// ===== rtl/mfto_top.sv
// Multi-function timer output stage with port fallback for error recovery.
// Assumes software drives the register port; pins are two-signal outputs.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ns
module mfto_top #(
  parameter int NCH = 5,
  parameter int CW = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [2*NCH-1:0] pin_out,
  output logic [2*NCH-1:0] pin_oe
);
  logic [1:0] rst_sync_r;
  logic rst_core_n;
  logic [NCH-1:0] start_r;
  logic [NCH-1:0] out_en_r;
  logic [1:0] level_ctl_r;
  logic [2*NCH-1:0] pin_func_r;
  logic [2*NCH-1:0] port_data_r;
  mfto_pkg::mfto_mode_t mode_r [NCH];
  logic [7:0] io_r [NCH];
  logic [2*NCH-1:0] tim_out;
  logic [15:0] rd_nxt;

  initial begin
    if (NCH != 5 || CW < 2) $error("mfto_top: unsupported channel set");
  end

  function automatic logic mode_ok(input int ch, input logic [2:0] m);
    unique case (m)
      3'h0, 3'h1: mode_ok = 1'b1;
      3'h2: mode_ok = ch <= mfto_pkg::MFTO_CH_PWM2_LAST;
      3'h3: mode_ok = ch >= mfto_pkg::MFTO_CH_PHASE_FIRST
                      && ch <= mfto_pkg::MFTO_CH_PHASE_LAST;
      3'h4, 3'h5: mode_ok = ch >= mfto_pkg::MFTO_CH_OE_FIRST;
      default: mode_ok = 1'b0;
    endcase
  endfunction : mode_ok

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_core_n = rst_sync_r[1];

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      start_r <= '0;
      out_en_r <= '0;
      level_ctl_r <= 2'h0;
      pin_func_r <= '0;
      port_data_r <= '0;
    end else if (reg_wr) begin
      unique case (reg_addr)
        mfto_pkg::MFTO_ADDR_START: start_r <= reg_wdata[NCH-1:0];
        mfto_pkg::MFTO_ADDR_OUT_EN: out_en_r <= reg_wdata[NCH-1:0];
        mfto_pkg::MFTO_ADDR_LEVEL_CTL: level_ctl_r <= reg_wdata[1:0];
        mfto_pkg::MFTO_ADDR_PIN_FUNC: pin_func_r <= reg_wdata[2*NCH-1:0];
        mfto_pkg::MFTO_ADDR_PORT_DATA: port_data_r <= reg_wdata[2*NCH-1:0];
        default: ;
      endcase
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic io_wr;
    logic oe_ok;
    assign io_wr = reg_wr && reg_addr == mfto_pkg::MFTO_ADDR_IO_BASE
                   && reg_wdata[15:13] == 3'(c);
    // Channels below 3 have no master enable gate
    assign oe_ok = (c < mfto_pkg::MFTO_CH_OE_FIRST) ? 1'b1 : out_en_r[c];

    always_ff @(posedge core_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
        mode_r[c] <= mfto_pkg::MFTO_MODE_NORMAL;
        io_r[c] <= 8'h0;
      end else begin
        if (reg_wr && reg_addr == mfto_pkg::MFTO_ADDR_MODE_BASE
            && reg_wdata[15:13] == 3'(c) && mode_ok(c, reg_wdata[2:0])) begin
          mode_r[c] <= mfto_pkg::mfto_mode_t'(reg_wdata[2:0]);
        end
        if (io_wr) begin
          io_r[c] <= reg_wdata[7:0];
        end
      end
    end

    mfto_chan #(.CW(CW)) u_chan (
      .core_clk(core_clk),
      .rst_n(rst_core_n),
      .run(start_r[c]),
      .mode(mode_r[c]),
      .io_ctl(io_wr ? reg_wdata[7:0] : io_r[c]),
      .io_wr(io_wr),
      .out_en(oe_ok),
      .cmp(CW'(mfto_pkg::MFTO_CMP_RST)),
      .out_a(tim_out[2*c]),
      .out_b(tim_out[2*c+1])
    );
  end

  // Timer function drives timer level; port function drives port data
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      for (int p = 0; p < 2*NCH; p++) begin
        pin_out[p] <= pin_func_r[p] ? tim_out[p] : port_data_r[p];
        pin_oe[p] <= pin_func_r[p] ? (p < 2*mfto_pkg::MFTO_CH_OE_FIRST
                                      || out_en_r[p/2]) : port_data_r[p] | pin_func_r[p];
      end
    end
  end

  always_comb begin
    rd_nxt = 16'h0;
    unique case (reg_addr)
      mfto_pkg::MFTO_ADDR_START: rd_nxt[NCH-1:0] = start_r;
      mfto_pkg::MFTO_ADDR_OUT_EN: rd_nxt[NCH-1:0] = out_en_r;
      mfto_pkg::MFTO_ADDR_LEVEL_CTL: rd_nxt[1:0] = level_ctl_r;
      mfto_pkg::MFTO_ADDR_PIN_FUNC: rd_nxt[2*NCH-1:0] = pin_func_r;
      mfto_pkg::MFTO_ADDR_PORT_DATA: rd_nxt[2*NCH-1:0] = tim_out;
      default: rd_nxt = 16'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      reg_rdata <= 16'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_nxt : 16'h0;
    end
  end
endmodule : mfto_top

// ===== rtl/mfto_pkg.sv
// Package for the multi-function timer output recovery block.
// Assumes a single 50 MHz clock domain and a plain strobe register port.
package mfto_pkg;

  typedef enum logic [2:0] {
    MFTO_MODE_NORMAL = 3'h0,
    MFTO_MODE_PWM_MODE_ONE = 3'h1,
    MFTO_MODE_PWM2 = 3'h2,
    MFTO_MODE_PHASE = 3'h3,
    MFTO_MODE_COMPLEMENTARY_PWM_MODE = 3'h4,
    MFTO_MODE_RPWM = 3'h5
  } mfto_mode_t;

  // Pin I/O control codes: initial level and level on compare match
  typedef enum logic [2:0] {
    MFTO_IO_DISABLED = 3'h0,
    MFTO_IO_I0_O0 = 3'h1,
    MFTO_IO_I0_O1 = 3'h2,
    MFTO_IO_I0_TG = 3'h3,
    MFTO_IO_I1_O0 = 3'h5,
    MFTO_IO_I1_O1 = 3'h6,
    MFTO_IO_I1_TG = 3'h7
  } mfto_io_t;

  localparam logic [3:0] MFTO_ADDR_START = 4'h0;
  localparam logic [3:0] MFTO_ADDR_OUT_EN = 4'h1;
  localparam logic [3:0] MFTO_ADDR_LEVEL_CTL = 4'h2;
  localparam logic [3:0] MFTO_ADDR_PIN_FUNC = 4'h3;
  localparam logic [3:0] MFTO_ADDR_PORT_DATA = 4'h4;
  localparam logic [3:0] MFTO_ADDR_MODE_BASE = 4'h8;
  localparam logic [3:0] MFTO_ADDR_IO_BASE = 4'hc;

  localparam int MFTO_IO_A_LSB = 0;
  localparam int MFTO_IO_B_LSB = 4;
  localparam int MFTO_IO_INIT_BIT = 2;
  localparam logic [7:0] MFTO_CMP_RST = 8'hff;
  localparam int MFTO_CH_OE_FIRST = 3;
  localparam int MFTO_CH_PWM2_LAST = 2;
  localparam int MFTO_CH_PHASE_FIRST = 1;
  localparam int MFTO_CH_PHASE_LAST = 2;

endpackage : mfto_pkg

// ===== rtl/mfto_chan.sv
// One timer channel: counter, compare match and the A and B waveform outputs.
// Assumes the top decodes mode, start, I/O-control writes and output enable.
`timescale 1ns/1ns
module mfto_chan #(
  parameter int CW = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire mfto_pkg::mfto_mode_t mode,
  input wire logic [7:0] io_ctl,
  input wire logic io_wr,
  input wire logic out_en,
  input wire logic [CW-1:0] cmp,
  output logic out_a,
  output logic out_b
);
  logic [CW-1:0] cnt_r;
  logic match;
  logic init_ok;

  initial begin
    if (CW < 2) $error("mfto_chan: counter too narrow");
  end

  function automatic logic next_lvl(input logic [2:0] io, input logic cur);
    unique case (io[1:0])
      2'h1: next_lvl = 1'b0;
      2'h2: next_lvl = 1'b1;
      2'h3: next_lvl = ~cur;
      default: next_lvl = cur;
    endcase
  endfunction : next_lvl

  assign match = run && (cnt_r == cmp);
  // Initialisation only lands where the output master enable permits
  assign init_ok = io_wr && out_en;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (run) begin
      cnt_r <= match ? '0 : cnt_r + 1'b1;
    end
  end

  // Levels keep tracking even while the pin serves the port
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_a <= 1'b0;
    end else if (init_ok && mode != mfto_pkg::MFTO_MODE_PWM2) begin
      out_a <= io_ctl[mfto_pkg::MFTO_IO_A_LSB + mfto_pkg::MFTO_IO_INIT_BIT];
    end else if (match) begin
      out_a <= next_lvl(io_ctl[2:0], out_a);
    end
  end

  // A side acts as the cycle register in PWM mode 2, so only B initialises there
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_b <= 1'b0;
    end else if (init_ok && mode != mfto_pkg::MFTO_MODE_PWM_MODE_ONE) begin
      out_b <= io_ctl[mfto_pkg::MFTO_IO_B_LSB + mfto_pkg::MFTO_IO_INIT_BIT];
    end else if (match && mode != mfto_pkg::MFTO_MODE_PWM_MODE_ONE) begin
      out_b <= next_lvl(io_ctl[6:4], out_b);
    end
  end
endmodule : mfto_chan

// ===== tb/mfto_props.sv
// Checker for mfto_top: reset quiet, read path, port takeover, initial levels.
// Assumes a bind to mfto_top; shadows pin function, port data and modes 0..2.
`timescale 1ns/1ns
module mfto_props #(
  parameter int NCH = 5,
  parameter int CW = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [2*NCH-1:0] pin_out,
  input wire logic [2*NCH-1:0] pin_oe
);
  logic [2*NCH-1:0] port_r, func_r;
  logic [2:0] mode_r [3];
  logic io_wr, ch_ok;
  assign io_wr = reg_wr && reg_addr == 4'hc;
  // Refused mode writes must leave the shadow copy alone
  assign ch_ok = reg_wdata[15:13] < 3'h3 && (reg_wdata[2:0] < 3'h3 ||
                 (reg_wdata[2:0] == 3'h3 && reg_wdata[15:13] != 3'h0));
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_r <= '0;
      func_r <= '0;
      mode_r <= '{default: 3'h0};
    end else if (reg_wr) begin
      if (reg_addr == 4'h4) port_r <= reg_wdata[2*NCH-1:0];
      if (reg_addr == 4'h3) func_r <= reg_wdata[2*NCH-1:0];
      if (reg_addr == 4'h8 && ch_ok) mode_r[reg_wdata[15:13]] <= reg_wdata[2:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property ($rose(rst_n) |-> (pin_out == '0 && pin_oe == '0) [*2])
    else $error("pins not quiet after reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 4'h5 |-> reg_rdata == '0)
    else $error("unmapped read not zero");
  a_port_enable: assert property ($stable(func_r) && $stable(port_r) && func_r == '0
    |-> pin_oe == port_r) else $error("port enables differ from port data");
  a_port_high: assert property ($stable(func_r) && func_r == '0
    |-> (pin_out & pin_oe) == pin_oe) else $error("port drives a low level");
  a_init_level: assert property (io_wr && reg_wdata[15:13] == 3'h0 && reg_wdata[1:0] == 2'h1
    && mode_r[0] != 3'h2 && func_r[0] ##1 !reg_wr |-> ##1 pin_out[0] == $past(reg_wdata[2], 2))
    else $error("initial level not applied");
  a_pwm_mode_one_b_keep: assert property (!reg_wr ##1 io_wr && reg_wdata[15:13] == 3'h1
    && mode_r[1] == 3'h1 |-> ##2 $stable(pin_out[3])) else $error("B side initialised");
  a_pwm2_cycle: assert property (!reg_wr ##1 io_wr && reg_wdata[15:13] == 3'h2
    && mode_r[2] == 3'h2 |-> ##2 $stable(pin_out[4])) else $error("cycle pin initialised");
  c_port_mode: cover property (func_r == '0 && port_r != '0);
  c_pwm_mode_one_init: cover property (io_wr && mode_r[1] == 3'h1);
  c_timer_read: cover property (reg_rd && reg_addr == 4'h4);
endmodule : mfto_props
bind mfto_top mfto_props #(.NCH(NCH), .CW(CW)) mfto_props_inst (.core_clk(core_clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe));

// ===== tb/mfto_top_bench.sv
// Bench for mfto_top: reset levels, initial levels, mode gating, port takeover.
// Assumes default parameters; a compare match comes about 256 cycles after start.
`timescale 1ns/1ns
module mfto_top_bench;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd;
  logic [9:0] pin_out, pin_oe;
  int errors = 0, checks = 0, cyc = 0;
  always #10 core_clk = ~core_clk;
  mfto_top mfto_top_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_out(pin_out), .pin_oe(pin_oe));
  task test_done;
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk
  task idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rdr(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    idle(1);
    reg_rd <= 1'b0;
    rd = reg_rdata;
  endtask : rdr
  task t_reset;
    chk(16'(pin_out), 16'h0000);
    chk(16'(pin_oe), 16'h0000);
    rdr(4'h5);
    chk(rd, 16'h0000);
  endtask : t_reset
  // Channel 0: initial high, low on match, then port takeover while the timer runs on
  task t_norm;
    wr(4'hc, 16'h0005);
    wr(4'h3, 16'h03ff);
    idle(3);
    chk(16'(pin_out[0]), 16'h0001);
    wr(4'h0, 16'h0001);
    idle(300);
    chk(16'(pin_out[0]), 16'h0000);
    wr(4'hc, 16'h0005);
    wr(4'h4, 16'h03ff);
    wr(4'h3, 16'h0000);
    idle(3);
    chk(16'(pin_oe), 16'h03ff);
    chk(16'(pin_out), 16'h03ff);
    idle(300);
    rdr(4'h4);
    chk(16'(rd[0]), 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'hc, 16'h0005);
    idle(300);
    rdr(4'h4);
    chk(16'(rd[0]), 16'h0001);
    wr(4'h3, 16'h03ff);
    idle(3);
    chk(16'(pin_out[0]), 16'h0001);
  endtask : t_norm
  task t_pwm_mode_one;
    wr(4'h8, 16'h2001);
    idle(2);
    wr(4'hc, 16'h2055);
    idle(3);
    chk(16'(pin_out[3:2]), 16'h0001);
  endtask : t_pwm_mode_one
  // Channel 2 takes mode 2; channel 4 must refuse it and stay in normal mode
  task t_pwm2;
    wr(4'h8, 16'h4002);
    idle(2);
    wr(4'hc, 16'h4055);
    idle(3);
    chk(16'(pin_out[5:4]), 16'h0002);
    wr(4'h1, 16'hffff);
    wr(4'h8, 16'h8002);
    wr(4'hc, 16'h8055);
    idle(3);
    chk(16'(pin_out[9:8]), 16'h0003);
  endtask : t_pwm2
  // Phase mode gating, restart sequences and channel 3 enable gating
  task t_recover;
    wr(4'h8, 16'h0001);
    wr(4'h8, 16'h0003);
    wr(4'hc, 16'h0050);
    idle(3);
    chk(16'(pin_out[1:0]), 16'h0000);
    wr(4'h8, 16'h2003);
    wr(4'hc, 16'h2050);
    idle(3);
    chk(16'(pin_out[3:2]), 16'h0002);
    wr(4'h0, 16'h0002);
    idle(300);
    chk(16'(pin_out[3:2]), 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h8, 16'h2001);
    wr(4'hc, 16'h2055);
    idle(3);
    chk(16'(pin_out[3:2]), 16'h0001);
    wr(4'h0, 16'h0002);
    idle(300);
    chk(16'(pin_out[3:2]), 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'hc, 16'h2055);
    idle(3);
    chk(16'(pin_out[3:2]), 16'h0001);
    wr(4'h8, 16'h6000);
    wr(4'hc, 16'h6005);
    wr(4'hc, 16'h6000);
    wr(4'h1, 16'h0007);
    idle(3);
    chk(16'(pin_oe[7:6]), 16'h0000);
    wr(4'hc, 16'h6005);
    idle(3);
    chk(16'(pin_out[6]), 16'h0000);
    wr(4'h2, 16'h0003);
    rdr(4'h2);
    chk(rd, 16'h0003);
    wr(4'h8, 16'h6004);
    wr(4'h1, 16'h001f);
    idle(3);
    chk(16'(pin_oe[7:6]), 16'h0003);
    wr(4'hc, 16'h6005);
    idle(3);
    chk(16'(pin_out[6]), 16'h0001);
  endtask : t_recover
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    idle(3);
    t_reset();
    t_norm();
    t_pwm_mode_one();
    t_pwm2();
    t_recover();
    test_done();
  end
endmodule : mfto_top_bench
